// *** bas_fifo.sv ***
`timescale 1ns/100ps
module bas_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_ptr;
    logic [PW:0]      rd_ptr;
    logic [PW:0]      next_wr_ptr;
    logic [PW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    // =====================================================================
    // Status and pointers
    // =====================================================================
    // Full when pointers differ only in the wrap bit.
    assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};
    assign out_valid = wr_ptr != rd_ptr;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr[PW-1:0]];

    always_comb begin
        next_wr_ptr = flush ? '0 : (push ? wr_ptr + 1'b1 : wr_ptr);
        next_rd_ptr = flush ? '0 : (pop ? rd_ptr + 1'b1 : rd_ptr);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage has no reset; only valid entries are ever read.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr[PW-1:0]] <= in_data;
        end
    end

endmodule : bas_fifo

// *** bas_host_model.sv ***
`timescale 1ns/100ps
module bas_host_model
    import bas_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Requests from the bench
    input  wire logic       req,
    input  wire bas_cmd_t   req_cmd,
    input  wire logic [7:0] req_len,
    input  wire logic       slow,
    input  wire logic [7:0] req_stall,
    output logic            done,
    // Burst control toward the sequencer
    output logic            start,
    output bas_cmd_t        cmd,
    output logic            cs_high,
    // Address stream from the sequencer
    input  wire logic       addr_valid,
    output logic            addr_ready
);
    logic [7:0] taken;
    logic [7:0] stall;
    logic       act;

    // Words are counted on the rising edge, where the handshake is decided.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            taken <= 8'h00;
        end else if (start) begin
            taken <= 8'h00;
        end else if (addr_valid && addr_ready) begin
            taken <= taken + 8'h01;
        end
    end

    // Controls move on the falling edge, clear of the sampling edge.
    always @(negedge ref_clk or posedge rst) begin
        if (rst) begin
            start <= 1'b0;
            cs_high <= 1'b1;
            addr_ready <= 1'b0;
            act <= 1'b0;
            done <= 1'b0;
            stall <= 8'h00;
            cmd <= '0;
        end else begin
            start <= 1'b0;
            done <= 1'b0;
            // The command is no longer valid once taken, so it is scrambled.
            if (start) begin
                cmd <= ~cmd;
            end
            if (req && !act) begin
                start <= 1'b1;
                cmd <= req_cmd;
                cs_high <= 1'b0;
                act <= 1'b1;
                stall <= req_stall;
            end else if (act && !start && taken == req_len) begin
                cs_high <= 1'b1;
                addr_ready <= 1'b0;
                act <= 1'b0;
                done <= 1'b1;
            end else if (act) begin
                if (stall != 8'h00) begin
                    stall <= stall - 8'h01;
                end
                addr_ready <= (stall == 8'h00) && !(slow && addr_ready);
            end
        end
    end
endmodule : bas_host_model

// *** bas_pkg.sv ***
package bas_pkg;

    // =====================================================================
    // Widths
    // =====================================================================
    localparam int ADDR_W = 22;

    // =====================================================================
    // First configuration register fields
    // =====================================================================
    localparam int          CFG_HYB_BIT   = 2;
    localparam int          CFG_LEN_MSB   = 1;
    localparam logic [1:0]  LEN_128       = 2'h0;
    localparam logic [1:0]  LEN_64        = 2'h1;
    localparam logic [1:0]  LEN_16        = 2'h2;
    localparam logic [1:0]  LEN_32        = 2'h3;
    localparam logic [2:0]  CFG_RESET     = 3'h7;

    // Group size in 16-bit words for each length code.
    localparam logic [6:0]  WORDS_128     = 7'h40;
    localparam logic [6:0]  WORDS_64      = 7'h20;
    localparam logic [6:0]  WORDS_32      = 7'h10;
    localparam logic [6:0]  WORDS_16      = 7'h08;

    // =====================================================================
    // Types
    // =====================================================================
    typedef enum logic [1:0] {
        BAS_IDLE = 2'h0,
        BAS_WRAP = 2'h1,
        BAS_LIN  = 2'h3
    } bas_state_t;

    typedef struct packed {
        logic              wrapped;
        logic [ADDR_W-1:0] addr;
    } bas_cmd_t;

endpackage : bas_pkg

// *** bas_sequencer.sv ***
// Notes on behaviour
// R01 - Wrapped bursts stay inside a group aligned to the configured group length; hybrid only for its first wrap.
// R02 - Group sizes of 16, 32, 64 and 128 bytes are supported.
// R03 - Wrap runs from start word to group end, then from group base to start.
// R04 - Hybrid burst first does exactly one full legacy-order wrap of the group.
// R05 - After that wrap, hybrid continues at the first word of the next group.
// R06 - Hybrid keeps going linearly until the host raises chip select.
// R07 - Config bit 2 clear selects hybrid sequencing for wrapped bursts.
// R08 - Config bit 2 set selects legacy wraps; resets to one.
// R09 - Addresses count 16-bit words; a group holds half its byte size.
// R10 - Hybrid select only matters for wrapped bursts; linear ignores it.
// R11 - Length code 00=128, 01=64, 10=16, 11=32 bytes; resets to 32.
// R12 - Linear burst increments one word per data word without wrapping.
`timescale 1ns/100ps
module bas_sequencer
    import bas_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Configuration write (from register write logic, same clock)
    input  wire logic              cfg_we,
    input  wire logic [2:0]        cfg_wdata,
    output logic      [2:0]        first_config_register,
    // Burst control from the command/address decoder
    input  wire logic              start,
    input  wire bas_cmd_t          cmd,
    input  wire logic              cs_high,
    // Word address stream to the array
    output logic                   addr_valid,
    input  wire logic              addr_ready,
    output logic      [ADDR_W-1:0] addr_out,
    output logic                   busy
);

    bas_state_t        state;
    bas_state_t        next_state;
    logic [ADDR_W-1:0] cur;
    logic [ADDR_W-1:0] next_cur;
    logic [ADDR_W-1:0] start_addr;
    logic [ADDR_W-1:0] next_start_addr;
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] next_mask;
    logic [2:0]        next_cfg;
    logic [ADDR_W-1:0] gen_mask;
    logic [ADDR_W-1:0] inc_wrap;
    logic [ADDR_W-1:0] next_group;
    logic              gen_valid;
    logic              gen_ready;
    logic              step;
    logic              wrap_done;

    // =====================================================================
    // Configuration
    // =====================================================================
    // The length code and hybrid bit come out of reset as legacy, 32 bytes.
    always_comb begin
        next_cfg = cfg_we ? cfg_wdata : first_config_register;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            first_config_register <= CFG_RESET;  // see R08 see R11
        end else begin
            first_config_register <= next_cfg;
        end
    end

    // Group mask in word addresses: half the byte size.
    always_comb begin
        case (first_config_register[CFG_LEN_MSB:0])  // see R11 see R02 see R09
            LEN_128: gen_mask = ADDR_W'(WORDS_128 - 7'h01);
            LEN_64:  gen_mask = ADDR_W'(WORDS_64 - 7'h01);
            LEN_16:  gen_mask = ADDR_W'(WORDS_16 - 7'h01);
            LEN_32:  gen_mask = ADDR_W'(WORDS_32 - 7'h01);
            default: gen_mask = ADDR_W'(WORDS_32 - 7'h01);
        endcase
    end

    // =====================================================================
    // Address generator
    // =====================================================================
    // Low bits advance inside the group, high bits stay put.
    assign inc_wrap   = (cur & ~mask) | ((cur + 1'b1) & mask);  // see R01 see R03
    assign next_group = (start_addr | mask) + 1'b1;             // see R05
    assign wrap_done  = inc_wrap == start_addr;
    assign gen_valid  = state != BAS_IDLE;
    assign step       = gen_valid & gen_ready;
    assign busy       = gen_valid;

    always_comb begin
        next_state      = state;
        next_cur        = cur;
        next_start_addr = start_addr;
        next_mask       = mask;
        case (state)
            BAS_IDLE: begin
                if (start) begin
                    next_cur        = cmd.addr;
                    next_start_addr = cmd.addr;
                    next_mask       = gen_mask;
                    // Hybrid bit only matters when the burst is wrapped.
                    next_state = cmd.wrapped ? BAS_WRAP : BAS_LIN;  // see R10
                end
            end
            BAS_WRAP: begin
                if (step) begin
                    if (wrap_done && !first_config_register[CFG_HYB_BIT]) begin
                        next_cur   = next_group;  // see R04 see R05 see R07
                        next_state = BAS_LIN;
                    end else begin
                        next_cur = inc_wrap;  // see R08 see R03
                    end
                end
            end
            BAS_LIN: begin
                if (step) begin
                    next_cur = cur + 1'b1;  // see R12 see R06
                end
            end
            default: next_state = BAS_IDLE;
        endcase
        // Chip select high ends any burst; it is the only terminator.
        if (cs_high) begin
            next_state = BAS_IDLE;  // see R06
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state      <= BAS_IDLE;
            cur        <= '0;
            start_addr <= '0;
            mask       <= '0;
        end else begin
            state      <= next_state;
            cur        <= next_cur;
            start_addr <= next_start_addr;
            mask       <= next_mask;
        end
    end

    // =====================================================================
    // Output buffer
    // =====================================================================
    // The FIFO lets the generator run ahead of the array; it is flushed when
    // the burst ends so stale addresses never leak into the next burst.
    bas_fifo #(
        .WIDTH (ADDR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .flush     (cs_high),
        .in_valid  (gen_valid),
        .in_ready  (gen_ready),
        .in_data   (cur),
        .out_valid (addr_valid),
        .out_ready (addr_ready),
        .out_data  (addr_out)
    );

    // =====================================================================
    // Checks
    // =====================================================================
    // Group base of the running burst, kept only so the checks below have
    // their own copy instead of trusting the live mask arithmetic.
    logic [ADDR_W-1:0] grp_base;
    logic [ADDR_W-1:0] next_grp_base;

    always_comb begin
        next_grp_base = grp_base;
        if (start && state == BAS_IDLE) begin
            next_grp_base = cmd.addr & ~gen_mask;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            grp_base <= '0;
        end else begin
            grp_base <= next_grp_base;
        end
    end

    AST_CFG_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // see R07
        cfg_we |=> (first_config_register == $past(cfg_wdata)))
        else $error("Configuration write did not land.");
    AST_WRAP_IN_GROUP: assert property (@(posedge ref_clk) disable iff (rst) // see R01
        (state == BAS_WRAP) |-> ((cur & ~mask) == grp_base))
        else $error("Wrapped address left its group.");
    AST_WRAP_STEP: assert property (@(posedge ref_clk) disable iff (rst) // see R03
        (state == BAS_WRAP && step && !cs_high && !wrap_done) |=> (cur == $past(inc_wrap)))
        else $error("Wrap step is not the next word in group.");
    AST_HYB_JUMP: assert property (@(posedge ref_clk) disable iff (rst) // see R05
        (state == BAS_WRAP && step && wrap_done && !cs_high && !first_config_register[CFG_HYB_BIT])
        |=> (state == BAS_LIN && cur == ((start_addr | mask) + 1'b1)))
        else $error("Hybrid did not jump to next group.");
    AST_LEGACY_STAYS: assert property (@(posedge ref_clk) disable iff (rst) // see R08
        (state == BAS_WRAP && first_config_register[CFG_HYB_BIT] && !cs_high)
        |=> (state == BAS_WRAP))
        else $error("Legacy wrap left wrap state.");
    AST_LIN_INC: assert property (@(posedge ref_clk) disable iff (rst) // see R12
        (state == BAS_LIN && step && !cs_high) |=> (cur == $past(cur) + 1'b1))
        else $error("Linear burst did not increment by one.");
    AST_CS_END: assert property (@(posedge ref_clk) disable iff (rst) // see R06
        cs_high |=> (state == BAS_IDLE && !addr_valid))
        else $error("Chip select high did not end burst.");
    AST_LIN_IGNORES: assert property (@(posedge ref_clk) disable iff (rst) // see R10
        (state == BAS_IDLE && start && !cmd.wrapped && !cs_high) |=> (state == BAS_LIN))
        else $error("Linear burst entered wrap state.");
    AST_MASK: assert property (@(posedge ref_clk) disable iff (rst) // see R11
        (first_config_register[CFG_LEN_MSB:0] == LEN_16) |-> (gen_mask == 22'h000007))
        else $error("16-byte group is not eight words.");
    AST_WRAP_FIRST: assert property (@(posedge ref_clk) disable iff (rst) // see R04
        (state == BAS_IDLE && start && cmd.wrapped && !cs_high) |=> (state == BAS_WRAP))
        else $error("Wrapped burst did not begin with a wrap.");

    COV_HYBRID: cover property (@(posedge ref_clk) disable iff (rst)
        state == BAS_WRAP ##1 state == BAS_LIN);
    COV_LEGACY_WRAP: cover property (@(posedge ref_clk) disable iff (rst)
        state == BAS_WRAP && step && wrap_done && first_config_register[2]);
    COV_LINEAR: cover property (@(posedge ref_clk) disable iff (rst)
        state == BAS_IDLE && start && !cmd.wrapped);
    COV_FULL: cover property (@(posedge ref_clk) disable iff (rst)
        gen_valid && !gen_ready);
    // A linear run that crosses a group boundary shows no wrap is applied.
    COV_LIN_CROSS: cover property (@(posedge ref_clk) disable iff (rst)
        state == BAS_LIN && step && ((cur & mask) == mask));

endmodule : bas_sequencer

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
    import bas_pkg::*;

    // =====================================================================
    // Signals and case table
    // =====================================================================
    typedef struct packed {
        logic [2:0]  cfg;
        logic        wrapped;
        logic [21:0] addr;
        logic [7:0]  len;
        logic        slow;
        logic [21:0] last;
    } bas_row_t;

    logic              ref_clk, rst, cfg_we, start, cs_high, addr_valid, addr_ready, busy;
    logic [2:0]        cfg_wdata, first_config_register;
    logic [ADDR_W-1:0] addr_out;
    bas_cmd_t          cmd, req_cmd;
    logic              req, slow, done;
    logic [7:0]        req_len, req_stall;
    logic [21:0]       seen[$];
    int                error_cnt, num_checks;

    // Each row ends with the address that its last word must carry.
    bas_row_t rows [14] = '{
        '{3'h0, 1'h1, 22'h2AB403, 8'h50, 1'h0, 22'h2AB44F},
        '{3'h1, 1'h1, 22'h2AB403, 8'h28, 1'h1, 22'h2AB427},
        '{3'h1, 1'h1, 22'h2AB42E, 8'h28, 1'h0, 22'h2AB447},
        '{3'h2, 1'h1, 22'h000002, 8'h0E, 1'h0, 22'h00000D},
        '{3'h2, 1'h1, 22'h3FFF8C, 8'h0E, 1'h1, 22'h3FFF95},
        '{3'h3, 1'h1, 22'h15550A, 8'h14, 1'h0, 22'h155513},
        '{3'h5, 1'h1, 22'h2AB403, 8'h28, 1'h0, 22'h2AB40A},
        '{3'h5, 1'h1, 22'h2AB42E, 8'h20, 1'h1, 22'h2AB42D},
        '{3'h6, 1'h1, 22'h000002, 8'h0C, 1'h0, 22'h000005},
        '{3'h6, 1'h1, 22'h00000C, 8'h08, 1'h0, 22'h00000B},
        '{3'h7, 1'h1, 22'h00000A, 8'h14, 1'h1, 22'h00000D},
        '{3'h4, 1'h1, 22'h2AB403, 8'h46, 1'h0, 22'h2AB408},
        '{3'h0, 1'h0, 22'h2AB403, 8'h16, 1'h0, 22'h2AB418},
        '{3'h7, 1'h0, 22'h00003E, 8'h28, 1'h1, 22'h000065}};

    bas_sequencer #(.FIFO_DEPTH(16)) bas_sequencer_inst (.ref_clk(ref_clk), .rst(rst),
        .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .first_config_register(first_config_register),
        .start(start), .cmd(cmd), .cs_high(cs_high), .addr_valid(addr_valid),
        .addr_ready(addr_ready), .addr_out(addr_out), .busy(busy));

    bas_host_model bas_host_model_inst (.ref_clk(ref_clk), .rst(rst), .req(req),
        .req_cmd(req_cmd), .req_len(req_len), .slow(slow), .req_stall(req_stall), .done(done),
        .start(start), .cmd(cmd), .cs_high(cs_high), .addr_valid(addr_valid),
        .addr_ready(addr_ready));

    // =====================================================================
    // Helpers
    // =====================================================================
    always #25 ref_clk = ~ref_clk;

    // Every accepted word is logged on the edge where it is taken.
    always @(posedge ref_clk) begin
        if (addr_valid && addr_ready) begin
            seen.push_back(addr_out);
        end
    end

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, want, got);
        end
    endtask : check

    // Hybrid after its wrap is simply base plus offset, so one line covers it.
    function automatic logic [21:0] exp_addr(input bas_row_t r, input int i);
        logic [21:0] w;
        logic [21:0] base;
        w = (r.cfg[1:0] == LEN_128) ? 22'h40 : (r.cfg[1:0] == LEN_64) ? 22'h20 :
            (r.cfg[1:0] == LEN_16) ? 22'h08 : 22'h10;
        base = r.addr & ~(w - 22'h1);
        if (!r.wrapped) return r.addr + 22'(i);
        if (r.cfg[2] || 22'(i) < w) return base | ((r.addr + 22'(i)) & (w - 22'h1));
        return base + 22'(i);
    endfunction : exp_addr

    task automatic run_row(input bas_row_t r, input logic [7:0] stl);
        int k;
        cfg_we <= 1'b1;
        cfg_wdata <= r.cfg;
        @(negedge ref_clk);
        cfg_we <= 1'b0;
        check("config", first_config_register, r.cfg);
        seen.delete();
        req <= 1'b1;
        req_cmd <= '{r.wrapped, r.addr};
        req_len <= r.len;
        slow <= r.slow;
        req_stall <= stl;
        @(negedge ref_clk);
        req <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 2000) begin
            @(posedge ref_clk);
            k++;
        end
        @(negedge ref_clk);
        check("burst_done", k < 2000, 1'b1);
        check("busy_end", busy, 1'b0);
        check("valid_end", addr_valid, 1'b0);
        check("count", seen.size(), r.len);
        check("last", seen[r.len - 8'h01], r.last);
        for (int i = 0; i < r.len; i++) begin
            check("addr", seen[i], exp_addr(r, i));
        end
    endtask : run_row

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        cfg_we = 1'b0;
        cfg_wdata = 3'h0;
        req = 1'b0;
        req_cmd = '0;
        req_len = 8'h01;
        slow = 1'b0;
        req_stall = 8'h00;
        error_cnt = 0;
        num_checks = 0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        check("config_reset", first_config_register, 3'h7);
        check("busy_reset", busy, 1'b0);
        rst <= 1'b0;
        // The first row stalls long enough to fill the FIFO before draining.
        for (int n = 0; n < 14; n++) begin
            run_row(rows[n], (n == 0) ? 8'h18 : 8'h00);
        end
        // A reset in mid-burst must drop the stream and restore config defaults.
        cfg_we <= 1'b1;
        cfg_wdata <= 3'h2;
        req <= 1'b1;
        req_cmd <= '{1'b0, 22'h000100};
        req_len <= 8'hFF;
        req_stall <= 8'h00;
        @(negedge ref_clk);
        cfg_we <= 1'b0;
        req <= 1'b0;
        repeat (6) @(negedge ref_clk);
        check("busy_mid", busy, 1'b1);
        rst <= 1'b1;
        @(negedge ref_clk);
        check("config_reset2", first_config_register, 3'h7);
        check("valid_reset2", addr_valid, 1'b0);
        check("busy_reset2", busy, 1'b0);
        rst <= 1'b0;
        run_row(rows[12], 8'h00);
        final_report();
    end

    // A hang is cut short at 40000 cycles, well past the expected run of under a thousand cycles.
    initial begin
        #2000000;
        error_cnt++;
        final_report();
    end
endmodule : testbench
